// *** bench/ffc_chain_peer.sv ***
/*
  Next device of a depth chain: hands each chain pulse back as a grant.
  Assumes clk_sys, a synchronous active-low reset and LAT of 2 or more.
*/
module ffc_chain_peer #(
  parameter int LAT = 3
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic chain_mode,
  input  wire logic write_chain_out_n,
  input  wire logic read_chain_out_n,
  output logic      write_chain_in_n,
  output logic      read_chain_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAT-1:0] wdly_r;
  logic [LAT-1:0] rdly_r;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      wdly_r <= '0;
      rdly_r <= '0;
    end else begin
      wdly_r <= {wdly_r[LAT-2:0], ~write_chain_out_n}; // Pass write turn
      rdly_r <= {rdly_r[LAT-2:0], ~read_chain_out_n}; // Pass read turn
    end
  end

  // High in reset picks chain mode; low ties the chain off
  assign write_chain_in_n = chain_mode & ~(resetn & wdly_r[LAT-1]);
  assign read_chain_in_n  = chain_mode & ~(resetn & rdly_r[LAT-1]);
endmodule

// *** bench/ffc_top_bench.sv ***
/*
  Self-checking bench of the flag and chain logic: random words, level
  sweeps across every flag threshold, both timing modes and a chain.
  Assumes DEPTH 256 and a chain peer that returns grants.
*/
module ffc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D  = 256;
  localparam int DW = ffc_pkg::DATA_W;
  localparam int N0 = 31; // Default offsets at this depth

  logic                     clk_sys = 1'b0, resetn = 1'b0, chain_mode = 1'b0;
  logic                     write_enable_n = 1'b1, read_enable_n = 1'b1;
  logic                     strap_first_word_fall_through = 1'b0, strap_partial_async = 1'b0;
  logic                     first_load_select_n = 1'b0;
  logic                     empty_offset_wr = 1'b0, full_offset_wr = 1'b0;
  logic                     write_chain_in_n, read_chain_in_n;
  logic                     write_chain_out_n, read_chain_out_n;
  logic                     full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n;
  logic [DW-1:0]            data_in = '0, data_out, last;
  logic [ffc_pkg::OFF_W-1:0] offset_data = '0;
  logic [DW-1:0]            q[$];
  logic                     first_word_fall_through, chain;
  logic                     later_dev = 1'b0;
  int                       num_errors = 0, tests_run = 0, seed = 32'h0000_59ef;
  int                       lvl, cap, m, n, wpulse, rpulse;

  always #2 clk_sys = ~clk_sys;

  // Chain pulse widths in cycles, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (resetn === 1'b1 && chain) begin
      wpulse += (write_chain_out_n === 1'b0);
      rpulse += (read_chain_out_n === 1'b0);
    end
  end

  ffc_top #(.DEPTH(D)) u_ffc_top (
    .clk_sys, .resetn, .data_in, .write_enable_n, .read_enable_n, .data_out,
    .strap_first_word_fall_through, .strap_partial_async, .first_load_select_n, .write_chain_in_n,
    .read_chain_in_n, .write_chain_out_n, .read_chain_out_n, .offset_data,
    .empty_offset_wr, .full_offset_wr, .full_flag_n, .empty_flag_n,
    .almost_full_flag_n, .almost_empty_flag_n
  );

  ffc_chain_peer #(.LAT(3)) u_ffc_chain_peer (
    .clk_sys, .resetn, .chain_mode, .write_chain_out_n, .read_chain_out_n,
    .write_chain_in_n, .read_chain_in_n
  );

  task automatic finish_test();
    $display("errors %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Expected flag levels for the current fill level
  function automatic logic [4:0] exp_flags();
    exp_flags[4] = (lvl >= cap) ? first_word_fall_through : ~first_word_fall_through;
    exp_flags[3] = (lvl == 0) ? first_word_fall_through : ~first_word_fall_through;
    exp_flags[2] = (lvl < cap - m);
    exp_flags[1] = (lvl > n + first_word_fall_through);
    exp_flags[0] = (lvl <= D / 2);
  endfunction

  function automatic logic can_rd();
    return first_word_fall_through ? (empty_flag_n === 1'b0) : (empty_flag_n === 1'b1);
  endfunction

  task automatic chk_flags();
    logic [4:0] e;
    repeat (5) @(negedge clk_sys);
    e = exp_flags();
    cmp_bit(full_flag_n, e[4]); // Room left
    cmp_bit(empty_flag_n, e[3]); // Words held
    cmp_bit(almost_full_flag_n, e[2]); // Near full
    cmp_bit(almost_empty_flag_n, e[1]); // Near empty
    if (!chain) cmp_bit(write_chain_out_n, e[0]); // Half level
  endtask

  task automatic write_step(input int k);
    for (int i = 0; i < k; i++) begin
      data_in = DW'($random(seed));
      write_enable_n = 1'b0;
      if (lvl < cap) begin // Taken only with room
        q.push_back(data_in);
        lvl++;
      end
      @(negedge clk_sys);
    end
    write_enable_n = 1'b1;
  endtask

  task automatic read_step(input int k);
    int t;
    for (int i = 0; i < k; i++) begin
      t = 0;
      while (!can_rd()) begin
        read_enable_n = 1'b1;
        @(negedge clk_sys);
        t++;
        if (t > 40) begin
          num_errors++;
          $display("mismatch at %0t: got 0 expected 1", $time);
          finish_test();
        end
      end
      if (first_word_fall_through) cmp_word(data_out, q[0]); // Word shown with ready
      read_enable_n = 1'b0;
      @(negedge clk_sys);
      if (!first_word_fall_through) cmp_word(data_out, q[0]); // Word after read
      last = q.pop_front();
      lvl--;
    end
    read_enable_n = 1'b1;
  endtask

  task automatic go_to(input int target);
    if (target > lvl)
      write_step(target - lvl);
    else
      read_step(lvl - target);
    chk_flags();
  endtask

  task automatic do_reset(input logic fw, input logic asy, input logic ch);
    logic [5:0] f;
    @(negedge clk_sys);
    resetn = 1'b0;
    strap_first_word_fall_through = fw;
    strap_partial_async = asy;
    chain_mode = ch;
    first_load_select_n = later_dev; // Low only on the first device
    first_word_fall_through = fw;
    chain = ch;
    lvl = 0;
    cap = D + fw;
    m = N0;
    n = N0;
    q.delete();
    wpulse = 0;
    rpulse = 0;
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    f = {full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n,
      write_chain_out_n, read_chain_out_n};
    cmp_word(DW'(f), DW'({1'b1, fw, 4'hb})); // Reset levels
    cmp_word(data_out, '0); // Output cleared
  endtask

  task automatic single_phase(input logic fw, input logic asy, input logic prog);
    int st[16];
    do_reset(fw, asy, 1'b0);
    if (prog) begin
      n = 1 + ({$random(seed)} % 60);
      m = 1 + ({$random(seed)} % 60);
      offset_data = ffc_pkg::OFF_W'(n);
      empty_offset_wr = 1'b1;
      @(negedge clk_sys);
      empty_offset_wr = 1'b0;
      full_offset_wr = 1'b1;
      offset_data = ffc_pkg::OFF_W'(m);
      @(negedge clk_sys);
      full_offset_wr = 1'b0;
    end
    write_step(1);
    cmp_bit(empty_flag_n, first_word_fall_through); // Not yet visible
    @(negedge clk_sys);
    cmp_bit(empty_flag_n, 1'b1); // Standard shows a word
    @(negedge clk_sys);
    cmp_bit(empty_flag_n, ~first_word_fall_through); // Fall-through word out
    if (first_word_fall_through) cmp_word(data_out, q[0]); // First word on outputs
    st = '{n, n + 1, n + 2, D / 2, D / 2 + 1, cap - m - 1, cap - m, cap, cap + 1,
      cap - m, cap - m - 1, D / 2, n + 1 + fw, n + fw, 1, 0};
    foreach (st[i]) go_to(st[i]);
    read_enable_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    read_enable_n = 1'b1;
    cmp_word(data_out, last); // Last word held
    chk_flags();
  endtask

  initial begin
    single_phase(1'b0, 1'b0, 1'b0);
    single_phase(1'b1, 1'b1, 1'b1);
    single_phase(1'b0, 1'b1, 1'b1);
    single_phase(1'b1, 1'b0, 1'b0);
    write_step(5);
    do_reset(1'b0, 1'b1, 1'b1);
    go_to(D);
    cmp_word(DW'(wpulse), DW'(1'b1)); // One write pulse at last place
    go_to(0);
    cmp_word(DW'(rpulse), DW'(1'b1)); // One read pulse at last place
    go_to(1);
    go_to(0); // Turns regained through the peer
    later_dev = 1'b1;
    do_reset(1'b0, 1'b0, 1'b1);
    write_enable_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    write_enable_n = 1'b1;
    chk_flags(); // Later device waits for its write turn
    finish_test();
  end
endmodule

// *** src/ffc_fifo.sv ***
/*
  Staging FIFO with parameterised width and depth, valid and ready on both
  sides. Assumes one clock and a synchronous active-low reset.
*/
module ffc_fifo #(
  parameter int W     = ffc_pkg::DATA_W,
  parameter int DEPTH = ffc_pkg::BUF_DEPTH
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  ffc_stream_if.consumer     in_s,
  ffc_stream_if.producer     out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_r;
  logic [AW:0]   wp_nxt;
  logic [AW:0]   rp_r;
  logic [AW:0]   rp_nxt;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  always_comb begin
    full   = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    empty  = (wp_r == rp_r);
    push   = in_s.valid && !full;
    pop    = out_s.ready && !empty;
    wp_nxt = wp_r + (AW+1)'(push);
    rp_nxt = rp_r + (AW+1)'(pop);
  end

  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_s.data;
    end
  end
endmodule

// *** src/ffc_pkg.sv ***
/*
  Shared constants of the flag and chain logic: data and offset widths,
  depth variants, staging buffer depth and default offsets.
  Assumes a single clock domain and a synchronous active-low reset.
*/
package ffc_pkg;

  localparam int DATA_W     = 18;
  localparam int OFF_W      = 12;
  localparam int DEPTH_DFLT = 256;
  localparam int BUF_DEPTH  = 16;

  // Depth variants that select the default offsets
  localparam int DEPTH_V0 = 32'h0000_0100;
  localparam int DEPTH_V1 = 32'h0000_0200;

  localparam logic [OFF_W-1:0] OFF_DFLT_V0 = 12'h01f;
  localparam logic [OFF_W-1:0] OFF_DFLT_V1 = 12'h03f;
  localparam logic [OFF_W-1:0] OFF_DFLT_V2 = 12'h07f;

  localparam logic [OFF_W-1:0] DATA_RST = 12'h000;

  // Default offset for a given array depth
  function automatic logic [OFF_W-1:0] off_dflt(input int depth);
    if (depth <= DEPTH_V0) begin
      return OFF_DFLT_V0;
    end
    if (depth <= DEPTH_V1) begin
      return OFF_DFLT_V1;
    end
    return OFF_DFLT_V2;
  endfunction

endpackage

// *** src/ffc_stream_if.sv ***
/*
  Valid/ready word stream between the flag logic and its staging buffer.
  Assumes both ends run on clk_sys.
*/
interface ffc_stream_if #(
  parameter int W = ffc_pkg::DATA_W
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// *** src/ffc_top.sv ***
/*
  Synchronous FIFO with full, empty, almost-full, almost-empty and half-full
  flags, optional first word fall through and daisy-chain depth expansion.
  Assumes write and read sides share clk_sys, straps are steady during the
  synchronous reset, and chain inputs come from a neighbouring device.
*/
// How it works
// - Standard mode: full flag low once all array words are held.
// - Fall-through mode: input ready low while space remains, high when none.
// - Fall-through capacity is array depth plus one output word.
// - Full/input-ready flag changes only on write-side clock edges.
// - Standard mode: empty flag low while no word is stored.
// - Fall-through: output ready falls as first word appears on outputs.
// - Output ready rises only after a true read with nothing left or, in chain mode, no read turn.
// - Empty/output-ready flag changes only on read-side clock edges.
// - Standard: almost full low when level reaches depth minus full offset.
// - Fall-through: almost full low at depth plus one minus offset.
// - Async almost full: set by writes, released by reads; sync: per edge.
// - Almost empty low at n words or fewer, n+1 in fall-through.
// - Default empty offset is 31, 63 or 127 by depth.
// - Async almost empty: set by reads, released by writes; sync: per edge.
// - Chain inputs tied low make write chain out the half-full flag.
// - Half flag falls on write above half, rises on read at half.
// - Chain mode: pulse write chain out on writing last location.
// - Chain mode: pulse read chain out on reading last location.
// - Reset clears pointers and sets the documented flag levels.
// - Writes ignored while full, reads ignored while empty.
// - Fall-through first word reaches outputs on third edge after write.
module ffc_top #(
  parameter int DEPTH  = ffc_pkg::DEPTH_DFLT,
  parameter int DATA_W = ffc_pkg::DATA_W,
  parameter int OFF_W  = ffc_pkg::OFF_W
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              write_enable_n,
  input  wire logic              read_enable_n,
  output logic      [DATA_W-1:0] data_out,
  input  wire logic              strap_first_word_fall_through,
  input  wire logic              strap_partial_async,
  input  wire logic              first_load_select_n,
  input  wire logic              write_chain_in_n,
  input  wire logic              read_chain_in_n,
  output logic                   write_chain_out_n,
  output logic                   read_chain_out_n,
  input  wire logic [OFF_W-1:0]  offset_data,
  input  wire logic              empty_offset_wr,
  input  wire logic              full_offset_wr,
  output logic                   full_flag_n,
  output logic                   empty_flag_n,
  output logic                   almost_full_flag_n,
  output logic                   almost_empty_flag_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 2);
  localparam int XW = ((CW > OFF_W) ? CW : OFF_W) + 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [XW-1:0] HALF = XW'(DEPTH / 2);
  localparam logic [CW-1:0] DEP  = CW'(DEPTH);

  // Array of the device, written from the staging buffer
  logic [DATA_W-1:0] mem [DEPTH];

  ffc_stream_if #(.W(DATA_W)) wr_s ();
  ffc_stream_if #(.W(DATA_W)) mem_s ();

  ffc_fifo #(
    .W     (DATA_W),
    .DEPTH (ffc_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .in_s    (wr_s),
    .out_s   (mem_s)
  );

  // Mode and permission state
  logic              first_word_fall_through_r;
  logic              async_r;
  logic              chain_r;
  logic              wtok_r;
  logic              wtok_nxt;
  logic              rtok_r;
  logic              rtok_nxt;
  logic [OFF_W-1:0]  empty_off_r;
  logic [OFF_W-1:0]  empty_off_nxt;
  logic [OFF_W-1:0]  full_off_r;
  logic [OFF_W-1:0]  full_off_nxt;

  // Data path state
  logic [CW-1:0]     total_r;
  logic [CW-1:0]     total_nxt;
  logic [CW-1:0]     main_cnt_r;
  logic [CW-1:0]     main_cnt_nxt;
  logic [AW-1:0]     wptr_r;
  logic [AW-1:0]     wptr_nxt;
  logic [AW-1:0]     wacc_r;
  logic [AW-1:0]     wacc_nxt;
  logic [AW-1:0]     rptr_r;
  logic [AW-1:0]     rptr_nxt;
  logic              outv_r;
  logic              outv_nxt;
  logic [DATA_W-1:0] data_out_r;
  logic [DATA_W-1:0] data_out_nxt;

  // Flag state
  logic              full_n_r;
  logic              full_n_nxt;
  logic              empty_n_r;
  logic              empty_n_nxt;
  logic              af_n_r;
  logic              af_n_nxt;
  logic              ae_n_r;
  logic              ae_n_nxt;
  logic              hf_n_r;
  logic              hf_n_nxt;
  logic              wco_n_r;
  logic              wco_n_nxt;
  logic              rco_n_r;
  logic              rco_n_nxt;

  logic [CW-1:0]     cap;
  logic              wr_go;
  logic              push_main;
  logic              rd_take;
  logic              leave;
  logic              wlast;
  logic              rlast;
  logic [XW-1:0]     tot_x;
  logic [XW-1:0]     af_thr;
  logic [XW-1:0]     ae_thr;
  logic              af_cond;
  logic              ae_cond;
  logic              hf_cond;

  // Transfer decisions
  always_comb begin
    cap       = DEP + CW'(first_word_fall_through_r);
    wr_go     = !write_enable_n && (total_r < cap) && wtok_r && wr_s.ready;
    push_main = mem_s.valid && mem_s.ready;
    if (first_word_fall_through_r) begin
      rd_take = (main_cnt_r != '0) && rtok_r && (!outv_r || !read_enable_n);
      leave   = outv_r && !read_enable_n;
    end else begin
      rd_take = !read_enable_n && (main_cnt_r != '0) && rtok_r;
      leave   = rd_take;
    end
    wlast = wr_go && (wacc_r == LAST);
    rlast = rd_take && (rptr_r == LAST);
  end

  assign wr_s.valid  = wr_go;
  assign wr_s.data   = data_in;
  assign mem_s.ready = (main_cnt_r < DEP);

  // Data path next values
  always_comb begin
    total_nxt    = total_r + CW'(wr_go) - CW'(leave);
    main_cnt_nxt = main_cnt_r + CW'(push_main) - CW'(rd_take);
    wptr_nxt     = wptr_r + AW'(push_main);
    wacc_nxt     = wacc_r + AW'(wr_go);
    rptr_nxt     = rptr_r + AW'(rd_take);
    outv_nxt     = first_word_fall_through_r && (rd_take || (outv_r && read_enable_n));
    data_out_nxt = rd_take ? mem[rptr_r] : data_out_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      total_r    <= '0;
      main_cnt_r <= '0;
      wptr_r     <= '0;
      wacc_r     <= '0;
      rptr_r     <= '0;
      outv_r     <= 1'b0;
      data_out_r <= DATA_W'(ffc_pkg::DATA_RST);
    end else begin
      total_r    <= total_nxt;
      main_cnt_r <= main_cnt_nxt;
      wptr_r     <= wptr_nxt;
      wacc_r     <= wacc_nxt;
      rptr_r     <= rptr_nxt;
      outv_r     <= outv_nxt;
      data_out_r <= data_out_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push_main) begin
      mem[wptr_r] <= mem_s.data;
    end
  end

  // Mode, offset and chain permission next values
  always_comb begin
    empty_off_nxt = empty_offset_wr ? offset_data : empty_off_r;
    full_off_nxt  = full_offset_wr ? offset_data : full_off_r;
    wtok_nxt      = wtok_r;
    rtok_nxt      = rtok_r;
    if (!chain_r) begin
      wtok_nxt = 1'b1;
      rtok_nxt = 1'b1;
    end else begin
      if (!write_chain_in_n) begin
        wtok_nxt = 1'b1;
      end else if (wlast) begin
        wtok_nxt = 1'b0;
      end
      if (!read_chain_in_n) begin
        rtok_nxt = 1'b1;
      end else if (rlast) begin
        rtok_nxt = 1'b0;
      end
    end
  end

  // Straps caught while the synchronous reset is held
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      first_word_fall_through_r      <= strap_first_word_fall_through;
      async_r     <= strap_partial_async;
      chain_r     <= write_chain_in_n && read_chain_in_n;
      wtok_r      <= !(write_chain_in_n && read_chain_in_n) || !first_load_select_n;
      rtok_r      <= !(write_chain_in_n && read_chain_in_n) || !first_load_select_n;
      empty_off_r <= ffc_pkg::off_dflt(DEPTH);
      full_off_r  <= ffc_pkg::off_dflt(DEPTH);
    end else begin
      first_word_fall_through_r      <= first_word_fall_through_r;
      async_r     <= async_r;
      chain_r     <= chain_r;
      wtok_r      <= wtok_nxt;
      rtok_r      <= rtok_nxt;
      empty_off_r <= empty_off_nxt;
      full_off_r  <= full_off_nxt;
    end
  end

  // Flag next values
  always_comb begin
    tot_x   = XW'(total_nxt);
    af_thr  = XW'(cap) - XW'(full_off_r);
    ae_thr  = XW'(empty_off_r) + XW'(first_word_fall_through_r);
    af_cond = (tot_x >= af_thr);
    ae_cond = (tot_x <= ae_thr);
    hf_cond = (tot_x > HALF);
    if (first_word_fall_through_r) begin
      full_n_nxt  = (total_nxt == cap);
      empty_n_nxt = !outv_nxt;
    end else begin
      full_n_nxt  = (total_nxt != cap);
      empty_n_nxt = (main_cnt_nxt != '0);
    end
    if (!async_r) begin
      af_n_nxt = !af_cond;
      ae_n_nxt = !ae_cond;
    end else begin
      af_n_nxt = af_cond ? (wr_go ? 1'b0 : af_n_r) : (leave ? 1'b1 : af_n_r);
      ae_n_nxt = ae_cond ? (leave ? 1'b0 : ae_n_r) : (wr_go ? 1'b1 : ae_n_r);
    end
    hf_n_nxt  = hf_cond ? (wr_go ? 1'b0 : hf_n_r) : (leave ? 1'b1 : hf_n_r);
    wco_n_nxt = chain_r ? !wlast : hf_n_nxt;
    rco_n_nxt = !(chain_r && rlast);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      full_n_r  <= 1'b1;
      empty_n_r <= strap_first_word_fall_through;
      af_n_r    <= 1'b1;
      ae_n_r    <= 1'b0;
      hf_n_r    <= 1'b1;
      wco_n_r   <= 1'b1;
      rco_n_r   <= 1'b1;
    end else begin
      full_n_r  <= full_n_nxt;
      empty_n_r <= empty_n_nxt;
      af_n_r    <= af_n_nxt;
      ae_n_r    <= ae_n_nxt;
      hf_n_r    <= hf_n_nxt;
      wco_n_r   <= wco_n_nxt;
      rco_n_r   <= rco_n_nxt;
    end
  end

  assign data_out            = data_out_r;
  assign full_flag_n         = full_n_r;
  assign empty_flag_n        = empty_n_r;
  assign almost_full_flag_n  = af_n_r;
  assign almost_empty_flag_n = ae_n_r;
  assign write_chain_out_n   = wco_n_r;
  assign read_chain_out_n    = rco_n_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_full_std;
    (!first_word_fall_through_r && total_r == DEP) |-> !full_flag_n;
  endproperty
  a_full_std: assert property (p_full_std) else $error("full flag not low at capacity");

  property p_ir_first_word_fall_through;
    (first_word_fall_through_r && total_r == DEP + CW'(1'b1)) |-> full_flag_n;
  endproperty
  a_ir_first_word_fall_through: assert property (p_ir_first_word_fall_through) else $error("input ready not high at depth plus one");

  property p_wr_ignored;
    (!full_flag_n && !first_word_fall_through_r && !write_enable_n && read_enable_n) |=> (total_r == $past(total_r));
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write taken while full");

  property p_empty_std;
    (!first_word_fall_through_r && $past(resetn)) |-> (empty_flag_n == (main_cnt_r != '0));
  endproperty
  a_empty_std: assert property (p_empty_std) else $error("empty flag disagrees with level");

  property p_or_hold;
    (first_word_fall_through_r && !empty_flag_n && read_enable_n) |=> !empty_flag_n;
  endproperty
  a_or_hold: assert property (p_or_hold) else $error("output ready rose without a read");

  property p_first_word;
    (first_word_fall_through_r && total_r == '0 && wr_go && !chain_r) |-> ##3 !empty_flag_n;
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not out on third edge");

  property p_half;
    (!chain_r && $past(wr_go) && XW'(total_r) > HALF) |-> !write_chain_out_n;
  endproperty
  a_half: assert property (p_half) else $error("half flag not low above half");

  property p_wchain;
    (chain_r && wlast) |=> !write_chain_out_n ##1 write_chain_out_n;
  endproperty
  a_wchain: assert property (p_wchain) else $error("write chain pulse missing");

  property p_rchain;
    (chain_r && rlast) |=> !read_chain_out_n ##1 read_chain_out_n;
  endproperty
  a_rchain: assert property (p_rchain) else $error("read chain pulse missing");

  property p_reset_flags;
    $rose(resetn) |-> (full_flag_n && almost_full_flag_n && !almost_empty_flag_n);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flag levels wrong after reset");

  c_full: cover property (!first_word_fall_through_r && !full_flag_n);
  c_first_word_fall_through_first: cover property (first_word_fall_through_r && $fell(empty_flag_n));
  c_chain: cover property (chain_r && !write_chain_out_n);
  c_half: cover property (!chain_r && $fell(write_chain_out_n));
endmodule
